// ### rtl/adc_frame_pkg.sv
// constants and types shared by the serial frame converter logic
package adc_frame_pkg;
  localparam int RES_BITS = 12;
  localparam int CTRL_BITS = 8;
  localparam int SEL_LO_BIT = 3;
  localparam int SEL_HI_BIT = 4;
  // positions count falling serial clock edges inside one 16-clock conversion
  localparam logic [3:0] POS_GAP = 4'h0;
  localparam logic [3:0] POS_TRACK_FIRST = 4'h1;
  localparam logic [3:0] POS_TRACK_LAST = 4'h3;
  localparam logic [3:0] POS_HOLD = 4'h4;
  localparam logic [3:0] POS_LAST = 4'hF;
  // rising edge index (from zero) that carries the last control bit
  localparam logic [3:0] RISE_CTRL_LAST = 4'h7;
  localparam logic [3:0] CNT_ONE = 4'h1;
  localparam logic [1:0] SEL_INPUT_A = 2'h0;
  localparam logic [1:0] SEL_INPUT_B = 2'h1;
  localparam logic [1:0] SEL_RST = 2'h0;
  localparam logic [RES_BITS-1:0] RESULT_RST = 12'h000;
  localparam logic [CTRL_BITS-1:0] CTRL_RST = 8'h00;
  localparam logic [3:0] CNT_RST = 4'h0;

  typedef enum logic [1:0] {
    MODE_DOWN = 2'b00,
    MODE_TRACK = 2'b01,
    MODE_HOLD = 2'b10
  } mode_type;
endpackage : adc_frame_pkg

// ### rtl/bit_sync.sv
// two flip-flop synchroniser for one level
`timescale 1ns/1ps
module bit_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_d,
  output logic o_q
);
  logic meta_ff;
  logic sync_ff;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      meta_ff <= RST_VAL;
      sync_ff <= RST_VAL;
    end else begin
      meta_ff <= i_d;
      sync_ff <= meta_ff;
    end
  end

  assign o_q = sync_ff;
endmodule : bit_sync

// ### rtl/dual_channel_adc_serial_frame.sv
// serial frame and conversion sequencing of a two-input 12-bit converter
//
// Operation
// - first three serial clocks track input
// - thirteen clocks convert; MSB out from clock five
// - fourth falling edge switches track to hold
// - output driven only while select low
// - power down when deselected and between conversions
// - back-to-back conversions retrack at the first fall after each sixteenth fall
// - deselect gates clock; low-clock select fall counts
// - high-clock select fall waits for real fall
// - first eight rising edges load control word
// - close select/clock falls may delay sampling one clock
// - first conversion after power-up uses input a
// - conversions start at least sixteen clocks apart
// - control bits four and three select channel
// - code 00 input a, 01 input b, 1x reads zero
// - result is straight binary, 4096 steps
`timescale 1ns/1ps
module dual_channel_adc_serial_frame (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_din,
  output logic o_dout,
  output logic o_dout_oe_n,
  input wire logic [adc_frame_pkg::RES_BITS-1:0] i_analog_input_a,
  input wire logic [adc_frame_pkg::RES_BITS-1:0] i_analog_input_b,
  output logic o_power_down,
  output logic o_tracking,
  output logic o_holding,
  output logic [adc_frame_pkg::RES_BITS-1:0] o_result,
  output logic o_result_chan_b,
  output logic o_result_valid
);

  // picks the sampled input for a channel select code
  function automatic logic [adc_frame_pkg::RES_BITS-1:0] pick_input(
    input logic [1:0] sel,
    input logic [adc_frame_pkg::RES_BITS-1:0] in_a,
    input logic [adc_frame_pkg::RES_BITS-1:0] in_b
  );
    logic [adc_frame_pkg::RES_BITS-1:0] val;
    val = adc_frame_pkg::RESULT_RST;
    case (sel)
      adc_frame_pkg::SEL_INPUT_A: val = in_a;
      adc_frame_pkg::SEL_INPUT_B: val = in_b;
      default: val = adc_frame_pkg::RESULT_RST;
    endcase
    return val;
  endfunction : pick_input

  // ---------------- link side, clocked by the serial clock and the select fall ----------------
  logic frame_rst;
  logic start_low_ff;
  logic started_ff;
  logic [3:0] fall_cnt_ff;
  logic [3:0] rise_cnt_ff;
  logic [3:0] pos_now;
  logic [3:0] nxt_pos;
  logic [3:0] out_idx;
  logic [adc_frame_pkg::CTRL_BITS-1:0] ctrl_sh_ff;
  logic [adc_frame_pkg::CTRL_BITS-1:0] ctrl_word;
  logic [1:0] next_sel_ff;
  logic [1:0] used_sel_ff;
  logic [adc_frame_pkg::RES_BITS-1:0] hold_ff;
  logic [adc_frame_pkg::RES_BITS-1:0] sampled;
  logic dout_ff;
  logic done_tgl_ff;
  adc_frame_pkg::mode_type mode;

  // deselect or system reset clears the edge counters, control shifter and serial output and gates the clock
  assign frame_rst = i_cs_n | ~i_resetn;

  // clock level at the select fall: low means that fall is the first falling edge
  always_ff @(negedge i_cs_n or negedge i_resetn) begin
    if (!i_resetn) begin
      start_low_ff <= 1'b0;
    end else begin
      start_low_ff <= ~i_sclk;
    end
  end

  assign pos_now = fall_cnt_ff + {3'h0, start_low_ff};
  assign nxt_pos = pos_now + adc_frame_pkg::CNT_ONE;
  // result bit for the coming fall: eleven at fall five down to zero at fall sixteen (wraps to 0)
  assign out_idx = adc_frame_pkg::POS_LAST - nxt_pos + adc_frame_pkg::CNT_ONE;

  // falling edges seen in this frame
  always_ff @(negedge i_sclk or posedge frame_rst) begin
    if (frame_rst) begin
      fall_cnt_ff <= adc_frame_pkg::CNT_RST;
      started_ff <= 1'b0;
    end else begin
      fall_cnt_ff <= fall_cnt_ff + adc_frame_pkg::CNT_ONE;
      started_ff <= 1'b1;
    end
  end

  // conversion phase from the falling-edge position
  always_comb begin
    mode = adc_frame_pkg::MODE_DOWN;
    if (i_cs_n || !(started_ff || start_low_ff)) begin
      mode = adc_frame_pkg::MODE_DOWN;
    end else begin
      case (pos_now)
        adc_frame_pkg::POS_GAP: mode = adc_frame_pkg::MODE_DOWN;
        adc_frame_pkg::POS_TRACK_FIRST,
        4'h2,
        adc_frame_pkg::POS_TRACK_LAST: mode = adc_frame_pkg::MODE_TRACK;
        default: mode = adc_frame_pkg::MODE_HOLD;
      endcase
    end
  end

  // rising edges of the frame; a late first rise simply shifts the word by one
  always_ff @(posedge i_sclk or posedge frame_rst) begin
    if (frame_rst) begin
      rise_cnt_ff <= adc_frame_pkg::CNT_RST;
    end else begin
      rise_cnt_ff <= rise_cnt_ff + adc_frame_pkg::CNT_ONE;
    end
  end

  assign ctrl_word = {ctrl_sh_ff[adc_frame_pkg::CTRL_BITS-2:0], i_din};

  always_ff @(posedge i_sclk or posedge frame_rst) begin
    if (frame_rst) begin
      ctrl_sh_ff <= adc_frame_pkg::CTRL_RST;
    end else if (rise_cnt_ff <= adc_frame_pkg::RISE_CTRL_LAST) begin
      ctrl_sh_ff <= ctrl_word;
    end
  end

  // select survives between frames; power-up default is input a
  always_ff @(posedge i_sclk or negedge i_resetn) begin
    if (!i_resetn) begin
      next_sel_ff <= adc_frame_pkg::SEL_RST;
    end else if (!i_cs_n && rise_cnt_ff == adc_frame_pkg::RISE_CTRL_LAST) begin
      next_sel_ff <= {ctrl_word[adc_frame_pkg::SEL_HI_BIT],
                      ctrl_word[adc_frame_pkg::SEL_LO_BIT]};
    end
  end

  assign sampled = pick_input(next_sel_ff, i_analog_input_a, i_analog_input_b);

  // hold capture at the fourth falling edge of each conversion
  always_ff @(negedge i_sclk or negedge i_resetn) begin
    if (!i_resetn) begin
      hold_ff <= adc_frame_pkg::RESULT_RST;
      used_sel_ff <= adc_frame_pkg::SEL_RST;
    end else if (!i_cs_n && nxt_pos == adc_frame_pkg::POS_HOLD) begin
      hold_ff <= sampled;
      used_sel_ff <= next_sel_ff;
    end
  end

  // serial data changes on falling edges, read by the host on the next rise
  always_ff @(negedge i_sclk or posedge frame_rst) begin
    if (frame_rst) begin
      dout_ff <= 1'b0;
    end else if (nxt_pos > adc_frame_pkg::POS_HOLD || nxt_pos == adc_frame_pkg::POS_GAP) begin
      // msb read at the fifth rise, lsb at the sixteenth
      dout_ff <= hold_ff[out_idx];
    end else begin
      dout_ff <= 1'b0;
    end
  end

  assign o_dout = dout_ff;
  assign o_dout_oe_n = i_cs_n;

  // one toggle per finished conversion, at its sixteenth falling edge
  always_ff @(negedge i_sclk or negedge i_resetn) begin
    if (!i_resetn) begin
      done_tgl_ff <= 1'b0;
    end else if (!i_cs_n && started_ff && nxt_pos == adc_frame_pkg::POS_GAP) begin
      done_tgl_ff <= ~done_tgl_ff;
    end
  end

  // ---------------- system side ----------------
  logic track_sync;
  logic hold_sync;
  logic down_sync;
  logic done_sync;
  logic done_seen_ff;
  logic [adc_frame_pkg::RES_BITS-1:0] result_ff;
  logic result_chan_ff;
  logic result_valid_ff;

  bit_sync #(.RST_VAL(1'b0)) u_sync_track (
    .i_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_d(mode == adc_frame_pkg::MODE_TRACK),
    .o_q(track_sync)
  );

  bit_sync #(.RST_VAL(1'b0)) u_sync_hold (
    .i_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_d(mode == adc_frame_pkg::MODE_HOLD),
    .o_q(hold_sync)
  );

  bit_sync #(.RST_VAL(1'b1)) u_sync_down (
    .i_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_d(mode == adc_frame_pkg::MODE_DOWN),
    .o_q(down_sync)
  );

  bit_sync #(.RST_VAL(1'b0)) u_sync_done (
    .i_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_d(done_tgl_ff),
    .o_q(done_sync)
  );

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      done_seen_ff <= 1'b0;
    end else begin
      done_seen_ff <= done_sync;
    end
  end

  // result word is steady from the toggle until the next hold edge
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      result_ff <= adc_frame_pkg::RESULT_RST;
      result_chan_ff <= 1'b0;
      result_valid_ff <= 1'b0;
    end else begin
      result_valid_ff <= done_sync ^ done_seen_ff;
      if (done_sync ^ done_seen_ff) begin
        result_ff <= hold_ff;
        result_chan_ff <= used_sel_ff[0];
      end
    end
  end

  assign o_tracking = track_sync;
  assign o_holding = hold_sync;
  assign o_power_down = down_sync;
  assign o_result = result_ff;
  assign o_result_chan_b = result_chan_ff;
  assign o_result_valid = result_valid_ff;
endmodule : dual_channel_adc_serial_frame

// ### tb/dual_channel_adc_serial_frame_asserts.sv
// port checker for the serial frame converter
`timescale 1ns/1ps
module dual_channel_adc_serial_frame_asserts (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_cs_n,
  input wire logic o_dout,
  input wire logic o_dout_oe_n,
  input wire logic o_power_down,
  input wire logic o_tracking,
  input wire logic o_holding,
  input wire logic [adc_frame_pkg::RES_BITS-1:0] o_result,
  input wire logic o_result_valid
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);
  sequence s_track_run; o_tracking [*6]; endsequence
  sequence s_hold_run; o_holding [*8]; endsequence
  property p_oe_cs; o_dout_oe_n == i_cs_n; endproperty
  property p_dout_quiet; i_cs_n |-> !o_dout; endproperty
  property p_pd_desel; i_cs_n [*4] |-> o_power_down; endproperty
  property p_one_mode; !(o_tracking && o_holding) && !(o_power_down && o_holding); endproperty
  property p_track_len; $rose(o_tracking) |-> s_track_run; endproperty
  property p_hold_len; $rose(o_holding) |-> s_hold_run; endproperty
  property p_hold_after_track; $rose(o_holding) |-> $past(o_tracking); endproperty
  property p_valid_gap; o_result_valid |=> !o_result_valid [*8]; endproperty
  property p_result_held; !o_result_valid |-> $stable(o_result); endproperty
  a_oe_cs: assert property (p_oe_cs) else $error("enable differs from select");
  a_dout_quiet: assert property (p_dout_quiet) else $error("dout busy");
  a_pd_desel: assert property (p_pd_desel) else $error("not powered down");
  a_one_mode: assert property (p_one_mode) else $error("modes overlap");
  a_track_len: assert property (p_track_len) else $error("track too short");
  a_hold_len: assert property (p_hold_len) else $error("hold too short");
  a_hold_after_track: assert property (p_hold_after_track) else $error("hold w/o track");
  a_valid_gap: assert property (p_valid_gap) else $error("results too close");
  a_result_held: assert property (p_result_held) else $error("result moved");
endmodule : dual_channel_adc_serial_frame_asserts
bind dual_channel_adc_serial_frame dual_channel_adc_serial_frame_asserts i_chk (.i_sys_clk,
  .i_resetn, .i_cs_n, .o_dout, .o_dout_oe_n, .o_power_down, .o_tracking, .o_holding,
  .o_result, .o_result_valid);

// ### tb/host_link_model.sv
// host serial port model: frames, control words and readback
`timescale 1ns/1ps
module host_link_model (
  input wire logic i_dout,
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_din
);
  logic [15:0] got[$];
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_din = 1'b0;
  end
  // last conversion of the frame may be cut short on purpose
  task automatic run_frame(input logic rest_hi, input logic [7:0] words[$], input int last);
    logic [15:0] rx;
    int n;
    o_sclk = rest_hi;
    #7;
    o_cs_n = 1'b0;
    #6;
    foreach (words[c]) begin
      n = (c == words.size() - 1) ? last : 16;
      for (int b = 0; b < n; b++) begin
        o_sclk = 1'b0;
        o_din = (b < 8) ? words[c][7 - b] : ~o_din;
        #6;
        o_sclk = 1'b1;
        rx = {rx[14:0], i_dout};
        #6;
      end
      if (n == 16) got.push_back(rx);
    end
    o_sclk = 1'b0;
    // clock parked low a while before deselect, so a cut conversion keeps its hold phase
    #42;
    o_cs_n = 1'b1;
    o_din = ~o_din;
    #6;
    o_sclk = rest_hi;
  endtask : run_frame
endmodule : host_link_model

// ### tb/dual_channel_adc_serial_frame_test.sv
// self-checking bench for the serial frame converter
`timescale 1ns/1ps
module dual_channel_adc_serial_frame_test;
  logic i_sys_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic sclk, cs_n, din, dout, pd, trk, hld, chan_b, valid;
  logic [adc_frame_pkg::RES_BITS-1:0] in_a = 12'h000, in_b = 12'h000, result;
  logic [31:0] lfsr = 32'hCB77;
  logic [7:0] w0, w1;
  logic [12:0] seen[$];
  int n_mismatch = 0;
  int checks = 0;
  int exp_sel = 0;
  always #2.5 i_sys_clk = ~i_sys_clk;
  always @(posedge i_sys_clk) if (valid === 1'b1) seen.push_back({chan_b, result});
  host_link_model i_host_link_model (.i_dout(dout), .o_sclk(sclk), .o_cs_n(cs_n), .o_din(din));
  dual_channel_adc_serial_frame i_dual_channel_adc_serial_frame (.i_sys_clk, .i_resetn,
    .i_sclk(sclk), .i_cs_n(cs_n), .i_din(din), .o_dout(dout), .o_dout_oe_n(),
    .i_analog_input_a(in_a), .i_analog_input_b(in_b), .o_power_down(pd), .o_tracking(trk),
    .o_holding(hld), .o_result(result), .o_result_chan_b(chan_b), .o_result_valid(valid));
  function automatic logic [31:0] next_rand(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : next_rand
  task automatic cmp_val(input string what, input logic [15:0] e, input logic [15:0] a);
    checks++;
    if (a !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, e, a);
    end
  endtask : cmp_val
  task automatic frame(input logic rest_hi, input logic [7:0] words[$], input int last);
    logic [12:0] exp[$];
    logic [11:0] r;
    lfsr = next_rand(lfsr);
    in_a = lfsr[11:0];
    in_b = lfsr[23:12];
    seen.delete();
    i_host_link_model.got.delete();
    foreach (words[c]) begin
      if (c < words.size() - 1 || last == 16) begin
        r = (exp_sel == 0) ? in_a : (exp_sel == 1) ? in_b : 12'h000;
        exp.push_back({exp_sel[0], r});
      end
      if (c < words.size() - 1 || last >= 8) exp_sel = words[c][4:3];
    end
    i_host_link_model.run_frame(rest_hi, words, last);
    repeat (10) @(posedge i_sys_clk);
    cmp_val("results", 16'(exp.size()), 16'(seen.size()));
    foreach (exp[k]) begin
      cmp_val("dout", {4'h0, exp[k][11:0]}, i_host_link_model.got[k]);
      cmp_val("result", {3'h0, exp[k]}, {3'h0, seen[k]});
    end
  endtask : frame
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : complete_run
  initial begin
    #50000;
    n_mismatch++;
    complete_run();
  end
  initial begin
    repeat (6) @(posedge i_sys_clk);
    #1 i_resetn = 1'b1;
    frame(1'b1, {8'hE9}, 16);
    frame(1'b0, {8'h40, 8'h0B, 8'h27}, 16);
    frame(1'b0, {8'h00}, 5);
    frame(1'b1, {8'h10}, 16);
    frame(1'b1, {8'h00}, 16);
    repeat (4) begin
      lfsr = next_rand(lfsr);
      w0 = lfsr[7:0] & 8'hEF;
      w1 = lfsr[15:8] & 8'hEF;
      frame(lfsr[16], {w0, w1}, 16);
    end
    complete_run();
  end
endmodule : dual_channel_adc_serial_frame_test
